// file: design/aac_pkg.sv
// Package with register map, field positions, reset values and timing counts.
package aac_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h4D;
  localparam logic [7:0] REG_INPUT_MODE_GAIN = 8'h00;
  localparam logic [7:0] REG_HEADPHONE_MIXER_SELECT = 8'h01;
  localparam logic [7:0] REG_SPEAKER_MIXER_SELECT = 8'h02;
  localparam logic [7:0] REG_LEFT_HEADPHONE_VOLUME = 8'h03;
  localparam logic [7:0] REG_RIGHT_HEADPHONE_VOLUME = 8'h04;
  localparam logic [7:0] REG_SPEAKER_VOLUME_CTRL = 8'h05;
  localparam logic [7:0] REG_RESERVED_SLOT = 8'h06;
  localparam logic [7:0] REG_DISTORTION_LIMITER_CTRL = 8'h07;
  localparam logic [7:0] REG_POWER_MANAGEMENT = 8'h08;
  localparam logic [7:0] REG_CHARGE_PUMP_CTRL = 8'h09;
  localparam logic [7:0] REG_SILICON_REVISION = 8'hFF;
  localparam int NUM_REGS = 10;
  localparam logic [7:0] RST_POWER_MANAGEMENT = 8'h01;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam int BIT_A_DIFF = 7;
  localparam int BIT_B_DIFF = 6;
  localparam int BIT_FIXED_FREQ = 7;
  localparam int BIT_SPK_MUTE = 6;
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_SPK_EN = 4;
  localparam int BIT_HPL_EN = 2;
  localparam int BIT_HPR_EN = 1;
  localparam int BIT_SWITCH = 0;
  localparam int BIT_PUMP_FIXED = 0;
  localparam int BIT_PUMP_SEL = 1;
  localparam logic [2:0] GAIN_EXTERNAL = 3'h7;
  // Modulator timing: centre 250 kHz, +/-20 kHz spread.
  localparam int CLK_HZ = 100000000;
  localparam int CENTRE_KHZ = 250;
  localparam int SPREAD_KHZ = 20;
  localparam int HALF_CENTRE = CLK_HZ / (CENTRE_KHZ * 1000 * 2);
  localparam int HALF_FAST = CLK_HZ / ((CENTRE_KHZ + SPREAD_KHZ) * 1000 * 2);
  localparam int HALF_SLOW = CLK_HZ / ((CENTRE_KHZ - SPREAD_KHZ) * 1000 * 2);
  // Signal level thresholds as percent of full scale.
  localparam int PUMP_RATE_PCT = 10;
  localparam int PUMP_RAIL_PCT = 25;
endpackage

// file: design/aac_modulator.sv
// Speaker modulator clock with optional spread spectrum from an LFSR.
`timescale 1ns/1ps
module aac_modulator
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic fixedFreq,
  output logic modClock
);
  logic [15:0] lfsr_reg;
  logic [9:0] count_reg;
  logic [9:0] halfLen;
  logic [9:0] curHalf_reg;

  // R11: random period choice.
  always_comb begin
    halfLen = 10'(HALF_CENTRE);
    if (!fixedFreq) begin
      if (lfsr_reg[0]) begin
        halfLen = 10'(HALF_FAST) + 10'(lfsr_reg[3:1] % 3'd3);
      end else begin
        halfLen = 10'(HALF_SLOW) - 10'(lfsr_reg[3:1] % 3'd3);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr_reg <= 16'hACE1;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // The draw is latched at each toggle; a length that changed every cycle would end
  // almost every half period at the first fast value and lose the slow side of the band.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= 10'h000;
      curHalf_reg <= 10'(HALF_CENTRE);
      modClock <= 1'b0;
    end else if (!run) begin
      count_reg <= 10'h000;
      curHalf_reg <= halfLen;
      modClock <= 1'b0;
    end else if (count_reg + 10'h001 >= curHalf_reg) begin
      count_reg <= 10'h000;
      curHalf_reg <= halfLen;
      modClock <= ~modClock;
    end else begin
      count_reg <= count_reg + 10'h001;
    end
  end

  // R11: each half period stays in band.
  a_mod_band: assert property (@(posedge clk) disable iff (reset) // R11
    run |-> count_reg < 10'(HALF_SLOW) && curHalf_reg >= 10'(HALF_FAST))
    else $error("modulator half period beyond band");
endmodule

// file: design/aac_pump_ctrl.sv
// Charge pump rate and rail selection from signal level.
`timescale 1ns/1ps
module aac_pump_ctrl
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] level,
  input wire logic fixedMode,
  input wire logic railSelect,
  output logic fastRate,
  output logic fullRail
);
  logic [15:0] lvlPct;
  assign lvlPct = 16'(level) * 16'd100;

  // R14: rate follows 10 percent threshold.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fastRate <= 1'b0;
    end else begin
      fastRate <= lvlPct > 16'(PUMP_RATE_PCT * 255);
    end
  end

  // R15: dynamic rails at 25 percent. R16: forced level. R20: select ignored when dynamic.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fullRail <= 1'b0;
    end else if (fixedMode) begin
      fullRail <= ~railSelect;
    end else begin
      fullRail <= lvlPct > 16'(PUMP_RAIL_PCT * 255);
    end
  end

  // R20: fixed mode rail is the inverse of select.
  a_pump_fixed: assert property (@(posedge clk) disable iff (reset) // R20
    fixedMode && $stable(fixedMode) && $stable(railSelect) |-> fullRail == ~$past(railSelect))
    else $error("fixed rail level wrong");
  // R15: dynamic rail follows level; the edge after reset still shows the reset value.
  a_pump_dyn: assert property (@(posedge clk) disable iff (reset) // R15
    !$past(reset) && !$past(fixedMode) |->
    fullRail == ($past(lvlPct) > 16'(PUMP_RAIL_PCT * 255)))
    else $error("dynamic rail level wrong");
  // R14: rate follows level.
  a_pump_rate: assert property (@(posedge clk) disable iff (reset) // R14
    !$past(reset) |-> fastRate == ($past(lvlPct) > 16'(PUMP_RATE_PCT * 255)))
    else $error("pump rate wrong");
endmodule

// file: design/aac_registers.sv
// Two-wire slave register bank and derived amplifier control outputs.
`timescale 1ns/1ps
// Operation
// R1: Respond only to seven-bit bus address; eighth bit is direction.
// R2: Direction one reads from device, zero writes to it.
// R3: Master sends address byte first after every start.
// R4: Nine configuration registers from address zero with power-on defaults.
// R5: Read-only revision register at the top address.
// R6: Master writes zero into unused bits.
// R7: Input A mode bit: stereo or differential.
// R8: Input B mode bit: stereo or differential.
// R9: Input A gain code; all-ones selects external resistor.
// R10: Input B gain code; all-ones selects external resistor.
// R11: Spread spectrum varies switching frequency around centre.
// R12: Enabled limiter reduces gain when distortion exceeds threshold.
// R13: Controller disables speaker before closing bypass switch.
// R14: Pump uses low rate below ten percent level.
// R15: Dynamic pump gives half rails below twenty-five percent.
// R16: Software may force either rail level.
// R17: Low-power phone mode bypasses and powers down mixers, volume.
// R18: Inputs selected by no mixer are powered down.
// R19: Write is address, register address, data, each acknowledged.
// R20: Fixed bit forces static rails; select ignored otherwise.
// R21: Writes to unmapped or revision addresses acknowledged, no effect.
// R22: Reads from unmapped addresses return zero.
module aac_registers
  import aac_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5A // Arbitrary value.
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic [7:0] signalLevel,
  input wire logic distortionHigh,
  output logic inputADifferential,
  output logic inputBDifferential,
  output logic [2:0] inputAPreampGain,
  output logic [2:0] inputBPreampGain,
  output logic inputAExternal,
  output logic inputBExternal,
  output logic [3:0] inputPowerOn,
  output logic mixerPowerOn,
  output logic speakerRun,
  output logic modClock,
  output logic limiterReduce,
  output logic analogSwitchClosed,
  output logic pumpFastRate,
  output logic pumpFullRail
);
  typedef enum {ST_IDLE, ST_ADDR, ST_REGADDR, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK, ST_IGNORE}
    aac_state_type;

  logic [7:0] regs_reg [NUM_REGS];
  logic [2:0] sclSync_reg;
  logic [2:0] sdaSync_reg;
  aac_state_type state_reg;
  aac_state_type after_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCount_reg;
  logic [7:0] pointer_reg;
  logic [7:0] readData;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sclHigh;
  logic sdaLevel;
  logic modClockInt;
  logic fastInt;
  logic fullInt;

  // Bit 2 of each stage is only compared against bit 1, never the raw first stage.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
    end else begin
      sclSync_reg <= {sclSync_reg[1:0], serialClock};
      sdaSync_reg <= {sdaSync_reg[1:0], serialDataIn};
    end
  end
  assign sclHigh = sclSync_reg[1];
  assign sdaLevel = sdaSync_reg[1];
  assign sclRise = sclSync_reg[1] & ~sclSync_reg[2];
  assign sclFall = ~sclSync_reg[1] & sclSync_reg[2];
  assign startSeen = sclHigh & sclSync_reg[2] & ~sdaSync_reg[1] & sdaSync_reg[2];
  assign stopSeen = sclHigh & sclSync_reg[2] & sdaSync_reg[1] & ~sdaSync_reg[2];

  // R22: unmapped reads give zero. R5: revision readable.
  always_comb begin
    readData = 8'h00;
    if (pointer_reg == REG_SILICON_REVISION) begin
      readData = REVISION;
    end else if (pointer_reg < 8'(NUM_REGS)) begin
      readData = regs_reg[pointer_reg[3:0]];
    end
  end

  // R3: every start restarts address phase.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bitCount_reg <= 4'h0;
      serialDataOe <= 1'b0;
      serialDataOut <= 1'b0;
      pointer_reg <= 8'h00;
    end else if (startSeen) begin
      state_reg <= ST_ADDR;
      bitCount_reg <= 4'h0;
      serialDataOe <= 1'b0;
    end else if (stopSeen) begin
      state_reg <= ST_IDLE;
      serialDataOe <= 1'b0;
    end else if (sclRise && (state_reg == ST_ADDR || state_reg == ST_REGADDR ||
                             state_reg == ST_WDATA)) begin
      shift_reg <= {shift_reg[6:0], sdaLevel};
      bitCount_reg <= bitCount_reg + 4'h1;
    end else if (sclRise && state_reg == ST_RACK) begin
      // Master not-acknowledge ends the read.
      after_reg <= sdaLevel ? ST_IGNORE : ST_RDATA;
    end else if (sclFall) begin
      case (state_reg)
        ST_ADDR: begin
          if (bitCount_reg == 4'h8) begin
            // R1: match seven-bit address. R2: direction bit.
            if (shift_reg[7:1] == DEV_ADDR) begin
              serialDataOe <= 1'b1;
              state_reg <= ST_ACK;
              after_reg <= shift_reg[0] ? ST_RDATA : ST_REGADDR;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        ST_REGADDR: begin
          if (bitCount_reg == 4'h8) begin
            // R19: register address byte acknowledged.
            pointer_reg <= shift_reg;
            serialDataOe <= 1'b1;
            state_reg <= ST_ACK;
            after_reg <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (bitCount_reg == 4'h8) begin
            serialDataOe <= 1'b1;
            state_reg <= ST_ACK;
            after_reg <= ST_WDATA;
            pointer_reg <= pointer_reg + 8'h01;
          end
        end
        ST_ACK: begin
          bitCount_reg <= 4'h0;
          if (after_reg == ST_RDATA) begin
            serialDataOe <= ~readData[7];
            shift_reg <= {readData[6:0], 1'b0};
            bitCount_reg <= 4'h1;
          end else begin
            serialDataOe <= 1'b0;
          end
          state_reg <= after_reg;
        end
        ST_RDATA: begin
          if (bitCount_reg == 4'h8) begin
            serialDataOe <= 1'b0;
            state_reg <= ST_RACK;
            pointer_reg <= pointer_reg + 8'h01;
          end else begin
            serialDataOe <= ~shift_reg[7];
            shift_reg <= {shift_reg[6:0], 1'b0};
            bitCount_reg <= bitCount_reg + 4'h1;
          end
        end
        ST_RACK: begin
          if (after_reg == ST_RDATA) begin
            serialDataOe <= ~readData[7];
            shift_reg <= {readData[6:0], 1'b0};
            bitCount_reg <= 4'h1;
            state_reg <= ST_RDATA;
          end else begin
            state_reg <= ST_IGNORE;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // R4: power-on defaults; R21: unmapped and revision writes change nothing.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= RST_OTHER;
      end
      regs_reg[REG_POWER_MANAGEMENT[3:0]] <= RST_POWER_MANAGEMENT;
    end else if (sclFall && state_reg == ST_WDATA && bitCount_reg == 4'h8 &&
                 pointer_reg < 8'(NUM_REGS) && pointer_reg != REG_RESERVED_SLOT) begin
      regs_reg[pointer_reg[3:0]] <= shift_reg;
    end
  end

  aac_modulator modulator (
    .clk(clk),
    .reset(reset),
    .run(speakerRun),
    .fixedFreq(regs_reg[REG_SPEAKER_VOLUME_CTRL[3:0]][BIT_FIXED_FREQ]),
    .modClock(modClockInt)
  );

  aac_pump_ctrl pump (
    .clk(clk),
    .reset(reset),
    .level(signalLevel),
    .fixedMode(regs_reg[REG_CHARGE_PUMP_CTRL[3:0]][BIT_PUMP_FIXED]),
    .railSelect(regs_reg[REG_CHARGE_PUMP_CTRL[3:0]][BIT_PUMP_SEL]),
    .fastRate(fastInt),
    .fullRail(fullInt)
  );

  // Derived outputs are registered so each top output comes from a flip-flop.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inputADifferential <= 1'b0;
      inputBDifferential <= 1'b0;
      inputAPreampGain <= 3'h0;
      inputBPreampGain <= 3'h0;
      inputAExternal <= 1'b0;
      inputBExternal <= 1'b0;
      inputPowerOn <= 4'h0;
      mixerPowerOn <= 1'b0;
      speakerRun <= 1'b0;
      modClock <= 1'b0;
      limiterReduce <= 1'b0;
      analogSwitchClosed <= 1'b0;
      pumpFastRate <= 1'b0;
      pumpFullRail <= 1'b0;
    end else begin
      // R7: input A mode. R8: input B mode.
      inputADifferential <= regs_reg[0][BIT_A_DIFF];
      inputBDifferential <= regs_reg[0][BIT_B_DIFF];
      // R9: input A gain. R10: input B gain.
      inputAPreampGain <= regs_reg[0][5:3];
      inputBPreampGain <= regs_reg[0][2:0];
      inputAExternal <= regs_reg[0][5:3] == GAIN_EXTERNAL;
      inputBExternal <= regs_reg[0][2:0] == GAIN_EXTERNAL;
      // R18: unselected inputs off.
      inputPowerOn <= regs_reg[1][7:4] | regs_reg[1][3:0] | regs_reg[2][3:0];
      // R17: low-power mode shuts phone mixers and the speaker.
      mixerPowerOn <= regs_reg[8][BIT_POWER_ON] && regs_reg[8][6:5] == 2'h0;
      speakerRun <= regs_reg[8][BIT_POWER_ON] && regs_reg[8][BIT_SPK_EN] &&
                    regs_reg[8][6:5] == 2'h0;
      modClock <= modClockInt;
      // R12: limiter enabled by nonzero threshold.
      limiterReduce <= regs_reg[7][7:4] != 4'h0 && distortionHigh;
      // R13: switch closes as commanded; sequencing is the controller's duty.
      analogSwitchClosed <= regs_reg[8][BIT_SWITCH];
      pumpFastRate <= fastInt;
      pumpFullRail <= fullInt;
    end
  end

  // R21: write at revision or unmapped address leaves registers 0 and 9 unchanged.
  a_rev_write: assert property (@(posedge clk) disable iff (reset) // R21
    pointer_reg >= 8'(NUM_REGS) |=> $stable(regs_reg[9]) && $stable(regs_reg[0]))
    else $error("unmapped write changed state");
  // R22: unmapped read gives zero.
  a_unmapped_zero: assert property (@(posedge clk) disable iff (reset) // R22
    pointer_reg >= 8'(NUM_REGS) && pointer_reg != REG_SILICON_REVISION |-> readData == 8'h00)
    else $error("unmapped read not zero");
  // R17: low-power stops mixers on the next cycle.
  a_lp_mixer: assert property (@(posedge clk) disable iff (reset) // R17
    regs_reg[8][6:5] != 2'h0 |=> !mixerPowerOn)
    else $error("mixer on in low power mode");
  // R12: no reduction while disabled.
  a_limit_off: assert property (@(posedge clk) disable iff (reset) // R12
    regs_reg[7][7:4] == 4'h0 |=> !limiterReduce)
    else $error("limiter acted while disabled");
  // R1: foreign address is never acknowledged.
  a_addr_match: assert property (@(posedge clk) disable iff (reset) // R1
    sclFall && state_reg == ST_ADDR && bitCount_reg == 4'h8 && shift_reg[7:1] != DEV_ADDR
    |=> !serialDataOe && state_reg == ST_IGNORE)
    else $error("acknowledged foreign address");
endmodule

// file: test/aac_bus_master.sv
// Two-wire bus master model with an open-drain data driver.
`timescale 1ns/1ps
module aac_bus_master (
  output logic serialClock,
  output logic dataLow,
  input wire logic dataLine
);
  localparam real Q = 31.25;

  initial begin
    serialClock = 1'b1;
    dataLow = 1'b0;
  end

  // Data only moves while the clock is low, so it is never read as a start or stop.
  task automatic bitIo(input logic b, output logic r);
    #Q dataLow <= !b;
    #Q serialClock <= 1'b1;
    #Q r = dataLine;
    #Q serialClock <= 1'b0;
  endtask

  task automatic startCond();
    #Q dataLow <= 1'b1;
    #Q serialClock <= 1'b0;
  endtask

  // The clock stands high and still between frames.
  task automatic stopCond();
    #Q dataLow <= 1'b1;
    #Q serialClock <= 1'b1;
    #Q dataLow <= 1'b0;
    #(4 * Q);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic l9, output logic [7:0] rx,
                      output logic r9);
    for (int i = 7; i >= 0; i--)
      bitIo(tx[i], rx[i]);
    bitIo(l9, r9);
  endtask

  // address first, then register and data
  task automatic regWrite(input logic [6:0] dev, input logic [7:0] ra, wd, output logic ok);
    logic [7:0] x;
    logic a0, a1, a2;
    startCond();
    xfer({dev, 1'b0}, 1'b1, x, a0);
    xfer(ra, 1'b1, x, a1);
    xfer(wd, 1'b1, x, a2);
    stopCond();
    ok = !a0 && !a1 && !a2;
  endtask

  // set pointer, then read with a final nack
  task automatic regRead(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] rd,
                         output logic ok);
    logic [7:0] x;
    logic a0, a1, a2, n;
    startCond();
    xfer({dev, 1'b0}, 1'b1, x, a0);
    xfer(ra, 1'b1, x, a1);
    stopCond();
    startCond();
    xfer({dev, 1'b1}, 1'b1, x, a2);
    xfer(8'hFF, 1'b1, rd, n);
    stopCond();
    ok = !a0 && !a1 && !a2;
  endtask
endmodule

// file: test/tb.sv
// Self-checking testbench for the amplifier control register bank.
`timescale 1ns/1ps
module tb;
  import aac_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value.
  logic clk, reset, dataLow, serialClock, serialDataOut, serialDataOe, distortionHigh;
  logic inputADifferential, inputBDifferential, inputAExternal, inputBExternal;
  logic mixerPowerOn, speakerRun, modClock, limiterReduce, analogSwitchClosed;
  logic pumpFastRate, pumpFullRail, ok;
  logic [2:0] inputAPreampGain, inputBPreampGain;
  logic [3:0] inputPowerOn;
  logic [7:0] signalLevel, rd;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  // Pull-up on the data line; any party pulling low wins.
  wire serialDataIn = !(dataLow || (serialDataOe && !serialDataOut));

  aac_registers #(.REVISION(REV)) i_dut (.clk, .reset, .serialClock, .serialDataIn,
    .serialDataOut, .serialDataOe, .signalLevel, .distortionHigh, .inputADifferential,
    .inputBDifferential, .inputAPreampGain, .inputBPreampGain, .inputAExternal,
    .inputBExternal, .inputPowerOn, .mixerPowerOn, .speakerRun, .modClock, .limiterReduce,
    .analogSwitchClosed, .pumpFastRate, .pumpFullRail);
  aac_bus_master i_master (.serialClock, .dataLow, .dataLine(serialDataIn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ra, wd);
    i_master.regWrite(DEV_ADDR, ra, wd, ok);
    chk({7'h00, ok}, 8'h01);
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic rdc(input logic [7:0] ra, exp);
    i_master.regRead(DEV_ADDR, ra, rd, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rd, exp);
  endtask

  task automatic setIn(input logic [7:0] l, input logic d);
    @(posedge clk);
    signalLevel <= l;
    distortionHigh <= d;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_defaults();
    for (int r = 0; r < NUM_REGS; r++)
      rdc(8'(r), 8'(r) == REG_POWER_MANAGEMENT ? RST_POWER_MANAGEMENT : RST_OTHER);
    rdc(REG_SILICON_REVISION, REV);
    rdc(8'h0A, 8'h00);
    chk({7'h00, analogSwitchClosed}, 8'h01);
    chk({6'h00, serialDataOut, serialDataOe}, 8'h00);
    $display("test defaults done");
  endtask

  task automatic t_input();
    wr(REG_INPUT_MODE_GAIN, 8'hFA);
    chk({inputADifferential, inputBDifferential, inputAPreampGain, inputBPreampGain}, 8'hFA);
    chk({6'h00, inputAExternal, inputBExternal}, 8'h02);
    wr(REG_INPUT_MODE_GAIN, 8'h1F);
    chk({inputADifferential, inputBDifferential, inputAPreampGain, inputBPreampGain}, 8'h1F);
    chk({6'h00, inputAExternal, inputBExternal}, 8'h01);
    rdc(REG_INPUT_MODE_GAIN, 8'h1F);
    $display("test input done");
  endtask

  task automatic t_address();
    for (int b = 0; b < 7; b++) begin
      i_master.regWrite(DEV_ADDR ^ (7'h01 << b), REG_INPUT_MODE_GAIN, 8'h00, ok);
      chk({7'h00, ok}, 8'h00);
    end
    rdc(REG_INPUT_MODE_GAIN, 8'h1F);
    $display("test address done");
  endtask

  task automatic t_ignored();
    logic [7:0] ad [3] = '{REG_RESERVED_SLOT, REG_SILICON_REVISION, 8'h0A};
    foreach (ad[i])
      wr(ad[i], 8'h55);
    rdc(REG_RESERVED_SLOT, 8'h00);
    rdc(REG_SILICON_REVISION, REV);
    rdc(8'h0A, 8'h00);
    rdc(REG_INPUT_MODE_GAIN, 8'h1F);
    $display("test ignored done");
  endtask

  task automatic t_power();
    wr(REG_HEADPHONE_MIXER_SELECT, 8'h12);
    wr(REG_SPEAKER_MIXER_SELECT, 8'h04);
    chk({4'h0, inputPowerOn}, 8'h07);
    wr(REG_SPEAKER_MIXER_SELECT, 8'h00);
    chk({4'h0, inputPowerOn}, 8'h03);
    wr(REG_POWER_MANAGEMENT, 8'h90);
    chk({5'h00, speakerRun, mixerPowerOn, analogSwitchClosed}, 8'h06);
    wr(REG_POWER_MANAGEMENT, 8'h80);
    wr(REG_POWER_MANAGEMENT, 8'h81);
    chk({5'h00, speakerRun, mixerPowerOn, analogSwitchClosed}, 8'h03);
    wr(REG_POWER_MANAGEMENT, 8'hD0);
    chk({5'h00, speakerRun, mixerPowerOn, analogSwitchClosed}, 8'h00);
    $display("test power done");
  endtask

  task automatic t_limiter();
    wr(REG_DISTORTION_LIMITER_CTRL, 8'h10);
    setIn(8'h00, 1'b1);
    chk({7'h00, limiterReduce}, 8'h01);
    setIn(8'h00, 1'b0);
    chk({7'h00, limiterReduce}, 8'h00);
    wr(REG_DISTORTION_LIMITER_CTRL, 8'h00);
    setIn(8'h00, 1'b1);
    chk({7'h00, limiterReduce}, 8'h00);
    $display("test limiter done");
  endtask

  task automatic t_pump();
    logic [7:0] lv [6] = '{8'h00, 8'h19, 8'h1A, 8'h3F, 8'h40, 8'hFF};
    foreach (lv[i]) begin
      setIn(lv[i], 1'b0);
      chk({6'h00, pumpFastRate, pumpFullRail}, {6'h00, lv[i] * 100 > PUMP_RATE_PCT * 255,
          lv[i] * 100 > PUMP_RAIL_PCT * 255});
    end
    wr(REG_CHARGE_PUMP_CTRL, 8'h01);
    setIn(8'h00, 1'b0);
    chk({7'h00, pumpFullRail}, 8'h01);
    wr(REG_CHARGE_PUMP_CTRL, 8'h03);
    setIn(8'hFF, 1'b0);
    chk({7'h00, pumpFullRail}, 8'h00);
    // A high level tells a dynamic full rail apart from an obeyed select bit.
    wr(REG_CHARGE_PUMP_CTRL, 8'h02);
    setIn(8'hFF, 1'b0);
    chk({7'h00, pumpFullRail}, 8'h01);
    $display("test pump done");
  endtask

  task automatic halfLen(output int n);
    logic s;
    s = modClock;
    n = 0;
    while (modClock === s && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic t_mod();
    int n, lo, hi;
    wr(REG_POWER_MANAGEMENT, 8'h90);
    wr(REG_SPEAKER_VOLUME_CTRL, 8'h80);
    halfLen(n);
    halfLen(n);
    chk({7'h00, n >= HALF_CENTRE - 1 && n <= HALF_CENTRE + 1}, 8'h01);
    wr(REG_SPEAKER_VOLUME_CTRL, 8'h00);
    halfLen(n);
    lo = 1000;
    hi = 0;
    repeat (8) begin
      halfLen(n);
      chk({7'h00, n >= HALF_FAST - 1 && n <= HALF_SLOW + 1}, 8'h01);
      lo = n < lo ? n : lo;
      hi = n > hi ? n : hi;
    end
    chk({7'h00, hi > lo}, 8'h01);
    $display("test modulator done");
  endtask

  // A reset in mid-run must bring back the defaults, stop speaker, mixers and inputs, and close the switch.
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({4'h0, speakerRun, mixerPowerOn, modClock, analogSwitchClosed}, 8'h01);
    chk({4'h0, inputPowerOn}, 8'h00);
    rdc(REG_INPUT_MODE_GAIN, RST_OTHER);
    rdc(REG_POWER_MANAGEMENT, RST_POWER_MANAGEMENT);
    $display("test reset done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    signalLevel = 8'h00;
    distortionHigh = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    t_defaults();
    t_input();
    t_address();
    t_ignored();
    t_power();
    t_limiter();
    t_pump();
    t_mod();
    t_reset();
    end_of_test();
  end
endmodule
